//--- include/sgsd_map.svh
// field layout, codes and reset values of the segment descriptor decoder
`ifndef SGSD_MAP_SVH
`define SGSD_MAP_SVH

// ----------------------------------------------------------------
// descriptor geometry
// ----------------------------------------------------------------
`define SGSD_DESC_BITS 128
`define SGSD_ADDR_BITS 64
`define SGSD_LEN_BITS 32
`define SGSD_NIB_BITS 4

// ----------------------------------------------------------------
// field positions, little-endian bit numbering
// ----------------------------------------------------------------
`define SGSD_ADDR_LSB 0
`define SGSD_LEN_LSB 64
`define SGSD_SUB_LSB 120
`define SGSD_TYPE_LSB 124

// ----------------------------------------------------------------
// identifier codes
// ----------------------------------------------------------------
`define SGSD_TYPE_SEGMENT 4'h2
`define SGSD_TYPE_LAST 4'h3
`define SGSD_SUB_ADDRESS 4'h0
`define SGSD_SUB_OFFSET 4'h1

// ----------------------------------------------------------------
// length alignment: multiple of sixteen bytes
// ----------------------------------------------------------------
`define SGSD_ALIGN_BITS 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SGSD_RST_ADDR 64'h0
`define SGSD_RST_LEN 32'h0
`define SGSD_RST_LEFT 28'h0

`endif

//--- include/sgsd_pkg.sv
// types shared by the segment descriptor decoder files
package sgsd_pkg;

   // list walk position
   typedef enum logic [1:0] {
      sgsd_st_idle  = 2'b00,
      sgsd_st_chain = 2'b01,
      sgsd_st_final = 2'b10
   } sgsd_state_t;

   // descriptor classification
   typedef enum logic [1:0] {
      sgsd_k_other   = 2'b00,
      sgsd_k_segment = 2'b01,
      sgsd_k_last    = 2'b10
   } sgsd_kind_t;

endpackage

//--- rtl/sgsd_field_split.sv
// splits a sixteen byte descriptor into its fields
`timescale 1ns/1ps
`include "sgsd_map.svh"

module sgsd_field_split
   import sgsd_pkg::*;
#(
   parameter int ADDR_W = `SGSD_ADDR_BITS,
   parameter int LEN_W = `SGSD_LEN_BITS
) (
   // raw descriptor
   input wire logic [`SGSD_DESC_BITS-1:0] desc,
   // fields
   output logic [ADDR_W-1:0] addr,
   output logic [LEN_W-1:0] len,
   output logic [`SGSD_NIB_BITS-1:0] sub_type,
   output logic [`SGSD_NIB_BITS-1:0] desc_type
);

   // little-endian byte order; bytes 14..12 reserved and not looked at
   assign addr = desc[`SGSD_ADDR_LSB +: ADDR_W];
   assign len = desc[`SGSD_LEN_LSB +: LEN_W];
   assign sub_type = desc[`SGSD_SUB_LSB +: `SGSD_NIB_BITS];
   assign desc_type = desc[`SGSD_TYPE_LSB +: `SGSD_NIB_BITS];

endmodule

//--- rtl/sgsd_range_check.sv
// length validity and address-plus-length overflow check
`timescale 1ns/1ps
`include "sgsd_map.svh"

module sgsd_range_check #(
   parameter int ADDR_W = `SGSD_ADDR_BITS,
   parameter int LEN_W = `SGSD_LEN_BITS,
   parameter int ALIGN_W = `SGSD_ALIGN_BITS
) (
   // operands
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [LEN_W-1:0] len,
   // verdicts
   output logic len_bad,
   output logic sum_over
);

   logic [ADDR_W:0] sum;
   logic len_zero;
   logic len_unaligned;

   // length must be nonzero and a multiple of sixteen
   assign len_zero = (len == '0);
   assign len_unaligned = (len[ALIGN_W-1:0] != '0);
   assign len_bad = len_zero | len_unaligned;

   // sum greater than two to the width: carry set and low part nonzero
   assign sum = {1'b0, addr} + {{(ADDR_W+1-LEN_W){1'b0}}, len};
   assign sum_over = sum[ADDR_W] & (sum[ADDR_W-1:0] != '0);

endmodule

//--- rtl/sgsd_decoder.sv
// segment and last-segment descriptor decoder with list walk tracking
//
// How it works
// - a segment descriptor with sub type zero gives the absolute next segment address.
// - sub type one makes the address an offset added to the transfer base.
// - the segment length must be nonzero and a multiple of sixteen, else flagged.
// - a segment descriptor whose address plus length passes 2^64 is an overflow error.
// - a last-segment descriptor with sub type zero gives the final segment address.
// - the final segment length must be nonzero and a multiple of sixteen, else flagged.
// - a last-segment descriptor whose address plus length passes 2^64 is an overflow error.
// - the sub type is taken from the low nibble of byte fifteen.
// - type code two in the high nibble of byte fifteen marks a segment descriptor.
// - type code three in the high nibble of byte fifteen marks a last-segment descriptor.
// - a chaining descriptor found inside the final segment is an error.
`timescale 1ns/1ps
`include "sgsd_map.svh"

module sgsd_decoder
   import sgsd_pkg::*;
#(
   parameter int ADDR_W = `SGSD_ADDR_BITS,
   parameter int LEN_W = `SGSD_LEN_BITS,
   parameter int ALIGN_W = `SGSD_ALIGN_BITS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // list control from the command logic
   input wire logic list_start,
   input wire logic [ADDR_W-1:0] list_base,
   // fetched descriptor
   input wire logic desc_valid,
   input wire logic [`SGSD_DESC_BITS-1:0] desc_data,
   // decode result
   output logic res_valid,
   output sgsd_kind_t res_kind,
   output logic res_offset,
   output logic [ADDR_W-1:0] res_addr,
   output logic [LEN_W-1:0] res_len,
   // error flags of the result
   output logic res_len_err,
   output logic res_ovf_err,
   output logic res_sub_err,
   output logic res_chain_err,
   output logic res_error,
   // list walk status
   output sgsd_state_t list_state,
   output logic [LEN_W-ALIGN_W-1:0] final_left,
   output logic list_done
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // compare an identifier nibble against a code
   function automatic logic nib_is(input logic [`SGSD_NIB_BITS-1:0] nib,
                                   input logic [`SGSD_NIB_BITS-1:0] code);
      nib_is = (nib == code);
   endfunction

   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------

   logic [ADDR_W-1:0] f_addr;
   logic [LEN_W-1:0] f_len;
   logic [`SGSD_NIB_BITS-1:0] f_sub;
   logic [`SGSD_NIB_BITS-1:0] f_type;

   sgsd_field_split #(
      .ADDR_W(ADDR_W),
      .LEN_W(LEN_W)
   ) u_split (
      .desc(desc_data),
      .addr(f_addr),
      .len(f_len),
      .sub_type(f_sub),
      .desc_type(f_type)
   );

   // ----------------------------------------------------------------
   // range checks
   // ----------------------------------------------------------------

   logic chk_len_bad;
   logic chk_over;

   sgsd_range_check #(
      .ADDR_W(ADDR_W),
      .LEN_W(LEN_W),
      .ALIGN_W(ALIGN_W)
   ) u_check (
      .addr(f_addr),
      .len(f_len),
      .len_bad(chk_len_bad),
      .sum_over(chk_over)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------

   sgsd_state_t state_r;
   sgsd_state_t state_nxt;
   logic [LEN_W-ALIGN_W-1:0] left_r;
   logic [LEN_W-ALIGN_W-1:0] left_nxt;
   logic done_r;
   logic done_nxt;

   logic res_valid_r;
   sgsd_kind_t res_kind_r;
   logic res_offset_r;
   logic [ADDR_W-1:0] res_addr_r;
   logic [LEN_W-1:0] res_len_r;
   logic res_len_err_r;
   logic res_ovf_err_r;
   logic res_sub_err_r;
   logic res_chain_err_r;
   logic res_error_r;

   // ----------------------------------------------------------------
   // classification
   // ----------------------------------------------------------------

   // type code decode from the high nibble
   wire is_seg = nib_is(f_type, `SGSD_TYPE_SEGMENT);
   wire is_last = nib_is(f_type, `SGSD_TYPE_LAST);
   wire is_chain = is_seg | is_last;

   // sub type decode from the low nibble
   wire sub_abs = nib_is(f_sub, `SGSD_SUB_ADDRESS);
   wire sub_off = nib_is(f_sub, `SGSD_SUB_OFFSET);
   wire sub_bad = is_chain & ~sub_abs & ~sub_off;

   // kind for the result
   sgsd_kind_t kind_nxt;
   assign kind_nxt = is_seg ? sgsd_k_segment :
                     is_last ? sgsd_k_last : sgsd_k_other;

   // ----------------------------------------------------------------
   // address resolution
   // ----------------------------------------------------------------

   // offset form is measured from the start of the transfer location
   wire [ADDR_W-1:0] addr_off = list_base + f_addr;
   // absolute form passes the field through as a byte address
   wire [ADDR_W-1:0] addr_res = sub_off ? addr_off : f_addr;

   // ----------------------------------------------------------------
   // error terms
   // ----------------------------------------------------------------

   // length rules for both chaining kinds
   wire seg_len_err = is_seg & chk_len_bad;
   wire last_len_err = is_last & chk_len_bad;
   wire len_err = seg_len_err | last_len_err;

   // address-plus-length overflow past two to the sixty-fourth
   wire seg_ovf_err = is_seg & chk_over;
   wire last_ovf_err = is_last & chk_over;
   wire ovf_err = seg_ovf_err | last_ovf_err;

   // chaining inside the final segment is illegal
   wire in_final = (state_r == sgsd_st_final);
   wire chain_err = in_final & is_chain;

   // any fault ends the list walk
   wire any_err = len_err | ovf_err | sub_bad | chain_err;

   // ----------------------------------------------------------------
   // final segment descriptor count
   // ----------------------------------------------------------------

   // number of sixteen byte descriptors the final segment holds
   wire [LEN_W-ALIGN_W-1:0] last_count = f_len[LEN_W-1:ALIGN_W];
   wire left_one = (left_r == {{(LEN_W-ALIGN_W-1){1'b0}}, 1'b1});
   wire [LEN_W-ALIGN_W-1:0] left_dec = left_r - {{(LEN_W-ALIGN_W-1){1'b0}}, 1'b1};

   // ----------------------------------------------------------------
   // list walk next state
   // ----------------------------------------------------------------

   always_comb begin
      state_nxt = state_r;
      left_nxt = left_r;
      done_nxt = 1'b0;
      if (list_start) begin
         // a new list always begins in the chained part
         state_nxt = sgsd_st_chain;
         left_nxt = `SGSD_RST_LEFT;
      end else if (desc_valid) begin
         unique case (state_r)
            sgsd_st_idle,
            sgsd_st_chain: begin
               if (any_err) begin
                  state_nxt = sgsd_st_idle;
               end else if (is_last) begin
                  // next segment fetched is the final one
                  state_nxt = sgsd_st_final;
                  left_nxt = last_count;
               end else begin
                  state_nxt = sgsd_st_chain;
               end
            end
            sgsd_st_final: begin
               if (chain_err) begin
                  state_nxt = sgsd_st_idle;
                  left_nxt = `SGSD_RST_LEFT;
               end else if (left_one) begin
                  // last descriptor of the list consumed
                  state_nxt = sgsd_st_idle;
                  left_nxt = `SGSD_RST_LEFT;
                  done_nxt = 1'b1;
               end else begin
                  left_nxt = left_dec;
               end
            end
            default: begin
               state_nxt = sgsd_st_idle;
               left_nxt = `SGSD_RST_LEFT;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // list walk registers
   // ----------------------------------------------------------------

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_r <= sgsd_st_idle;
         left_r <= `SGSD_RST_LEFT;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         left_r <= left_nxt;
         done_r <= done_nxt;
      end
   end

   // ----------------------------------------------------------------
   // result strobe
   // ----------------------------------------------------------------

   // one cycle pulse a cycle after each descriptor not dropped under a list start
   always_ff @(posedge mclk) begin
      if (reset) begin
         res_valid_r <= 1'b0;
      end else begin
         res_valid_r <= desc_valid & ~list_start;
      end
   end

   // ----------------------------------------------------------------
   // result fields
   // ----------------------------------------------------------------

   // captured with each descriptor taken without a list start, held until the next one
   always_ff @(posedge mclk) begin
      if (reset) begin
         res_kind_r <= sgsd_k_other;
         res_offset_r <= 1'b0;
         res_addr_r <= `SGSD_RST_ADDR;
         res_len_r <= `SGSD_RST_LEN;
      end else if (desc_valid & ~list_start) begin
         res_kind_r <= kind_nxt;
         res_offset_r <= is_chain & sub_off;
         res_addr_r <= addr_res;
         res_len_r <= f_len;
      end
   end

   // ----------------------------------------------------------------
   // result error flags
   // ----------------------------------------------------------------

   always_ff @(posedge mclk) begin
      if (reset) begin
         res_len_err_r <= 1'b0;
         res_ovf_err_r <= 1'b0;
         res_sub_err_r <= 1'b0;
         res_chain_err_r <= 1'b0;
         res_error_r <= 1'b0;
      end else if (desc_valid & ~list_start) begin
         res_len_err_r <= len_err;
         res_ovf_err_r <= ovf_err;
         res_sub_err_r <= sub_bad;
         res_chain_err_r <= chain_err;
         res_error_r <= any_err;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   assign res_valid = res_valid_r;
   assign res_kind = res_kind_r;
   assign res_offset = res_offset_r;
   assign res_addr = res_addr_r;
   assign res_len = res_len_r;
   assign res_len_err = res_len_err_r;
   assign res_ovf_err = res_ovf_err_r;
   assign res_sub_err = res_sub_err_r;
   assign res_chain_err = res_chain_err_r;
   assign res_error = res_error_r;
   assign list_state = state_r;
   assign final_left = left_r;
   assign list_done = done_r;

endmodule

//--- dv/sgsd_decoder_monitor.sv
// assertion checker for the segment descriptor decoder ports
`timescale 1ns/1ps
module sgsd_decoder_monitor
   import sgsd_pkg::*;
#(
   parameter int ADDR_W = 64,
   parameter int LEN_W = 32,
   parameter int ALIGN_W = 4
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // list control and descriptor in
   input wire logic list_start,
   input wire logic [ADDR_W-1:0] list_base,
   input wire logic desc_valid,
   input wire logic [127:0] desc_data,
   // decode result
   input wire logic res_valid,
   input wire sgsd_kind_t res_kind,
   input wire logic res_offset,
   input wire logic [ADDR_W-1:0] res_addr,
   input wire logic [LEN_W-1:0] res_len,
   input wire logic res_len_err,
   input wire logic res_ovf_err,
   input wire logic res_sub_err,
   input wire logic res_chain_err,
   input wire logic res_error,
   // list walk status
   input wire sgsd_state_t list_state,
   input wire logic [LEN_W-ALIGN_W-1:0] final_left,
   input wire logic list_done
);
   // field decode of the incoming descriptor
   wire tk = desc_valid && !list_start;
   wire [3:0] ty = desc_data[127:124];
   wire [3:0] sb = desc_data[123:120];
   wire ch = (ty == 4'h2) || (ty == 4'h3);
   wire [64:0] sum = {1'b0, desc_data[63:0]} + {33'h0, desc_data[95:64]};
   wire lbad = (desc_data[95:64] == 32'h0) || (desc_data[67:64] != 4'h0);

   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   seg_kind_a: assert property (tk && ty == 4'h2 |=> res_valid && res_kind == sgsd_k_segment)
      else $error("segment type missed");
   last_kind_a: assert property (tk && ty == 4'h3 |=> res_valid && res_kind == sgsd_k_last)
      else $error("last segment type missed");
   abs_addr_a: assert property (tk && ch && sb == 4'h0 |=> res_addr == $past(desc_data[63:0]))
      else $error("absolute address wrong");
   off_addr_a: assert property (tk && ch && sb == 4'h1 |=> res_offset &&
      res_addr == $past(list_base) + $past(desc_data[63:0])) else $error("offset address wrong");
   len_chk_a: assert property (tk && ch |=> res_len_err == $past(lbad))
      else $error("length check wrong");
   ovf_chk_a: assert property (tk && ch |=> res_ovf_err == $past(sum > 65'h1_0000_0000_0000_0000))
      else $error("overflow check wrong");
   sub_chk_a: assert property (tk && ch && sb > 4'h1 |=> res_sub_err && res_error)
      else $error("bad sub type not flagged");
   chain_err_a: assert property (tk && ch && list_state == sgsd_st_final |=>
      res_chain_err ##0 list_state == sgsd_st_idle) else $error("chaining in final missed");
   len_raw_a: assert property (tk |=> res_len == $past(desc_data[95:64]))
      else $error("length field wrong");

   // main scenarios reached
   cover property (res_valid && res_kind == sgsd_k_last);
   cover property (list_done);
   cover property (res_valid && res_chain_err);
endmodule

bind sgsd_decoder sgsd_decoder_monitor #(.ADDR_W(ADDR_W), .LEN_W(LEN_W), .ALIGN_W(ALIGN_W)) u_mon (
   .mclk(mclk), .reset(reset), .list_start(list_start), .list_base(list_base),
   .desc_valid(desc_valid), .desc_data(desc_data), .res_valid(res_valid), .res_kind(res_kind),
   .res_offset(res_offset), .res_addr(res_addr), .res_len(res_len), .res_len_err(res_len_err),
   .res_ovf_err(res_ovf_err), .res_sub_err(res_sub_err), .res_chain_err(res_chain_err),
   .res_error(res_error), .list_state(list_state), .final_left(final_left),
   .list_done(list_done));

//--- dv/sgsd_host_mem.sv
// host memory model holding descriptor lists for the decoder
`timescale 1ns/1ps
module sgsd_host_mem (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // fetch request
   input wire logic fetch,
   input wire logic [7:0] idx,
   // descriptor out
   output logic desc_valid,
   output logic [127:0] desc_data
);
   logic [127:0] mem [256];

   // segment length in whole sixteen byte units, never zero for k above zero
   function automatic logic [31:0] seg_len(input int k);
      return 32'(k) << 4;
   endfunction

   // builds one little-endian descriptor, reserved bytes random
   function automatic logic [127:0] mk(input logic [3:0] ty, input logic [3:0] sb,
      input logic [31:0] ln, input logic [63:0] ad);
      return {ty, sb, 24'($urandom), ln, ad};
   endfunction

   // answers one cycle after a fetch; data line scrambled while idle
   always @(posedge mclk) begin
      desc_valid <= fetch && !reset;
      desc_data <= fetch ? mem[idx] : ~desc_data;
   end

   // quiet line at time zero
   initial begin
      desc_valid = 1'b0;
      desc_data = '0;
   end
endmodule

//--- dv/testbench.sv
// self-checking bench for the segment descriptor decoder
`timescale 1ns/1ps
module testbench;
   import sgsd_pkg::*;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic list_start = 1'b0;
   logic [63:0] list_base = 64'h0;
   logic fetch = 1'b0;
   logic [7:0] idx = 8'h0;
   logic desc_valid, res_valid, res_offset, res_len_err, res_ovf_err;
   logic res_sub_err, res_chain_err, res_error, list_done;
   logic [127:0] desc_data;
   logic [63:0] res_addr, ea;
   logic [31:0] res_len, el;
   logic [27:0] final_left;
   logic [27:0] left = 28'h0;
   logic [1:0] st = 2'h0;
   sgsd_kind_t res_kind, ek;
   sgsd_state_t list_state;
   logic ev, ed, chk, eo, ele, eov, esb, ech, c;
   logic [3:0] ty, sb;
   int fails = 0;
   int comparisons = 0;
   int n = 0;

   always #4 mclk = ~mclk;

   sgsd_host_mem u_sgsd_host_mem (.mclk(mclk), .reset(reset), .fetch(fetch), .idx(idx),
      .desc_valid(desc_valid), .desc_data(desc_data));

   sgsd_decoder u_sgsd_decoder (.mclk(mclk), .reset(reset), .list_start(list_start),
      .list_base(list_base), .desc_valid(desc_valid), .desc_data(desc_data),
      .res_valid(res_valid), .res_kind(res_kind), .res_offset(res_offset), .res_addr(res_addr),
      .res_len(res_len), .res_len_err(res_len_err), .res_ovf_err(res_ovf_err),
      .res_sub_err(res_sub_err), .res_chain_err(res_chain_err), .res_error(res_error),
      .list_state(list_state), .final_left(final_left), .list_done(list_done));

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   task automatic test_done();
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // appends one descriptor to host memory
   task automatic add(input logic [3:0] t, input logic [3:0] s, input logic [31:0] l,
      input logic [63:0] a);
      u_sgsd_host_mem.mem[n] = u_sgsd_host_mem.mk(t, s, l, a);
      n++;
   endtask

   // starts a list, then fetches all stored descriptors back to back
   task automatic go(input logic [63:0] base);
      @(posedge mclk);
      #1 list_start = 1'b1;
      list_base = base;
      @(posedge mclk);
      #1 list_start = 1'b0;
      for (int i = 0; i < n; i++) begin
         fetch = 1'b1;
         idx = 8'(i);
         @(posedge mclk);
         #1;
      end
      fetch = 1'b0;
      repeat (3) @(posedge mclk);
      #1 n = 0;
   endtask

   // random non-chaining type code
   function automatic logic [3:0] nt();
      logic [3:0] t;
      t = 4'($urandom % 14);
      return (t < 4'h2) ? t : t + 4'h2;
   endfunction

   // random list, sometimes cut short at one faulty descriptor
   task automatic rl();
      int ns, nf, bad;
      logic [127:0] v;
      ns = $urandom % 3;
      nf = 1 + $urandom % 4;
      bad = $urandom % 8;
      for (int i = 0; i < ns; i++) add(4'h2, 4'($urandom % 2),
         u_sgsd_host_mem.seg_len(1 + $urandom % 8), {$urandom, $urandom});
      add(4'h3, 4'($urandom % 2), u_sgsd_host_mem.seg_len(nf), {$urandom, $urandom});
      for (int i = 0; i < nf; i++) add(nt(), 4'($urandom % 2), $urandom, {$urandom, $urandom});
      if (bad <= ns) begin
         v = u_sgsd_host_mem.mem[bad];
         case ($urandom % 4)
            0: v[67:64] = 4'($urandom % 15 + 1);
            1: v[95:64] = 32'h0;
            2: v[123:120] = 4'($urandom % 14 + 2);
            default: v[63:0] = 64'hffff_ffff_ffff_ffff;
         endcase
         u_sgsd_host_mem.mem[bad] = v;
         n = bad + 1;
      end else if (bad == ns + 1) begin
         u_sgsd_host_mem.mem[n - 1][127:124] = 4'h2 + 4'($urandom % 2);
      end
      go({$urandom, $urandom});
   endtask

   // reference decode and list walk, taken at each rising edge
   always @(posedge mclk) begin
      ev = 1'b0;
      ed = 1'b0;
      chk = 1'b0;
      if (reset) begin
         st = 2'h0;
         left = 28'h0;
         ek = sgsd_k_other;
         {eo, ea, el, ele, eov, esb, ech} = '0;
         chk = 1'b1;
      end else if (list_start) begin
         st = 2'h1;
         left = 28'h0;
      end else if (desc_valid) begin
         ty = desc_data[127:124];
         sb = desc_data[123:120];
         c = (ty == 4'h2) || (ty == 4'h3);
         ek = (ty == 4'h2) ? sgsd_k_segment : (ty == 4'h3) ? sgsd_k_last : sgsd_k_other;
         eo = c && sb == 4'h1;
         ea = (sb == 4'h1) ? list_base + desc_data[63:0] : desc_data[63:0];
         el = desc_data[95:64];
         ele = c && (el == 32'h0 || el[3:0] != 4'h0);
         eov = c && ({1'b0, desc_data[63:0]} + el > 65'h1_0000_0000_0000_0000);
         esb = c && sb > 4'h1;
         ech = c && st == 2'h2;
         if (ele || eov || esb || ech) begin
            st = 2'h0;
            left = 28'h0;
         end else if (st == 2'h2) begin
            left = left - 28'h1;
            ed = (left == 28'h0);
            st = ed ? 2'h0 : st;
         end else if (ty == 4'h3) begin
            st = 2'h2;
            left = el[31:4];
         end else begin
            // idle or chained part both continue in the chained part
            st = 2'h1;
         end
         ev = 1'b1;
         chk = 1'b1;
      end
   end

   // outputs compared where settled
   always @(negedge mclk) begin
      cmp(res_valid, ev, "result strobe");
      cmp(list_state, st, "list state");
      cmp(final_left, left, "final count");
      cmp(list_done, ed, "list done");
      if (chk) begin
         cmp(res_kind, ek, "kind");
         cmp(res_offset, eo, "offset flag");
         cmp(res_addr, ea, "address");
         cmp(res_len, el, "length");
         cmp(res_len_err, ele, "length error");
         cmp(res_ovf_err, eov, "overflow error");
         cmp(res_sub_err, esb, "sub type error");
         cmp(res_chain_err, ech, "chain error");
         cmp(res_error, ele | eov | esb | ech, "any error");
      end
   end

   // main sequence
   initial begin
      void'($urandom(60));
      repeat (12) @(posedge mclk);
      #1 reset = 1'b0;
      $display("reset test done");
      add(4'h2, 4'h0, 32'h10, 64'h1000);
      add(4'h3, 4'h1, 32'h20, 64'h20);
      add(4'h0, 4'h0, 32'h0, 64'h0);
      add(4'h5, 4'h0, 32'h7, 64'h0);
      go(64'hffff_ffff_ffff_fff0);
      add(4'h2, 4'h0, 32'h0, 64'h0);
      go(64'h0);
      add(4'h2, 4'h0, 32'h18, 64'h0);
      go(64'h0);
      add(4'h3, 4'h0, 32'h8, 64'h0);
      go(64'h0);
      add(4'h2, 4'h2, 32'h10, 64'h0);
      go(64'h0);
      add(4'h2, 4'h0, 32'h10, 64'hffff_ffff_ffff_fff0);
      add(4'h2, 4'h0, 32'h20, 64'hffff_ffff_ffff_fff0);
      go(64'h0);
      add(4'h3, 4'h0, 32'h10, 64'hffff_ffff_ffff_fff1);
      go(64'h0);
      add(4'h3, 4'h0, 32'h20, 64'h0);
      add(4'h0, 4'h0, 32'h0, 64'h0);
      add(4'h3, 4'h0, 32'h10, 64'h0);
      go(64'h0);
      // one descriptor taken in idle, then one dropped under a list start
      add(4'h6, 4'h1, 32'h5, 64'h40);
      @(posedge mclk);
      #1 fetch = 1'b1;
      idx = 8'h0;
      repeat (2) @(posedge mclk);
      #1 fetch = 1'b0;
      list_start = 1'b1;
      @(posedge mclk);
      #1 list_start = 1'b0;
      n = 0;
      $display("corner test done");
      repeat (300) rl();
      $display("random test done");
      test_done();
   end

   // watchdog well beyond the expected run
   initial begin
      #(8 * 20000);
      fails++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      test_done();
   end
endmodule
